// ---- design/dim_ctrl.sv ----
/*
 Address multiplexer and strobe generator for a four-bank DRAM array:
 automatic and processor-driven all-bank initialisation, externally
 timed access and automatic access with hidden/forced refresh.
 Assumes one 25 MHz clock; all pins arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module dim_ctrl (
	input wire logic mclk,
	input wire logic rst_n,
	input wire dim_pkg::dim_mode_t mode_sel,
	input wire logic [1:0] eoc_sel,
	input wire logic [8:0] row_addr_in,
	input wire logic [8:0] col_addr_in,
	input wire logic [1:0] bank_sel_in,
	input wire logic address_latch_strobe,
	input wire logic device_select_n,
	input wire logic row_strobe_in_n,
	input wire logic column_strobe_in_n,
	input wire logic row_column_select,
	input wire logic refresh_request_in_n,
	input wire logic write_in_n,
	output logic [8:0] mux_address_out,
	output logic mux_address_oe,
	output logic [3:0] row_strobe_n,
	output logic column_strobe_n,
	output logic write_strobe_n,
	output logic refresh_io_o,
	output logic refresh_io_oe
);
	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [6:0] pin_s;
	logic ads_s, cs_n_s, ras_in_s, cas_in_s, rc_s, refresh_request_in_s, win_s;

	dim_sync #(.W(7)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in({address_latch_strobe, device_select_n, row_strobe_in_n,
			column_strobe_in_n, row_column_select, refresh_request_in_n,
			write_in_n}),
		.sync_out(pin_s)
	);
	assign {ads_s, cs_n_s, ras_in_s, cas_in_s, rc_s, refresh_request_in_s, win_s} = pin_s;

	// Previous synchronised values for edge detection
	logic ras_p_q, cas_p_q, rc_p_q;
	// Address and bank latches
	logic [8:0] row_lat_q, col_lat_q;
	logic [1:0] bank_q;
	// Internal refresh (row) counter
	logic [8:0] rcnt_q;
	// Phase and delay counters
	logic [1:0] gdiv_q;
	logic [2:0] dly_q;
	logic col_phase_q;
	logic req_q;

	// One-hot decode of the bank bits
	function automatic logic [3:0] bank_dec(input logic [1:0] b);
		bank_dec = 4'h1 << b;
	endfunction

	// Item_a value from the select bits
	function automatic logic [8:0] eoc_val(input logic [1:0] s);
		unique case (s)
			2'h1: eoc_val = dim_pkg::EOC_255;
			2'h2: eoc_val = dim_pkg::EOC_511;
			default: eoc_val = dim_pkg::EOC_127;
		endcase
	endfunction

	wire logic ras_fall = ras_p_q && !ras_in_s;
	wire logic cas_fall = cas_p_q && !cas_in_s;
	wire logic rc_fall = rc_p_q && !rc_s;
	wire logic rc_rise = !rc_p_q && rc_s;
	wire logic gclk_fall = cas_p_q && !cas_in_s;
	wire logic is_ai = mode_sel == dim_pkg::DIM_AUTO_INIT;
	wire logic is_aa = mode_sel == dim_pkg::DIM_AUTO_ACCESS;

	////////////////////////////////////////////////////////////////////
	// Edge history
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ras_p_q <= 1'b1;
			cas_p_q <= 1'b1;
			rc_p_q <= 1'b1;
		end
		else
		begin
			ras_p_q <= ras_in_s;
			cas_p_q <= cas_in_s;
			rc_p_q <= rc_s;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Address latches follow while strobe high; row and bank hold after it falls, column keeps following in automatic init
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			row_lat_q <= dim_pkg::CNT_RST;
			col_lat_q <= dim_pkg::CNT_RST;
			bank_q <= dim_pkg::BANK_RST;
		end
		else if (ads_s)
		begin
			// Processor advances the address; latched each cycle
			row_lat_q <= row_addr_in;
			col_lat_q <= col_addr_in;
			bank_q <= bank_sel_in;
		end
		else if (is_ai)
		begin
			// External counter supplies columns during init
			col_lat_q <= col_addr_in;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Strobe generator clock divider: counts falling edges of the clock
	always_ff @(posedge mclk)
	begin
		if (!rst_n || !is_ai)
			gdiv_q <= 2'h0;
		else if (gclk_fall)
			gdiv_q <= gdiv_q + 2'h1;
	end

	// Row strobe phase: low half is upper two of four periods
	wire logic ai_ras_low = gdiv_q[1];

	////////////////////////////////////////////////////////////////////
	// Row/column phase and delay counter shared by all four modes
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			col_phase_q <= 1'b0;
			dly_q <= 3'h0;
		end
		else
		begin
			unique case (mode_sel)
				dim_pkg::DIM_AUTO_INIT:
				begin
					// Count cycles since row strobe dropped
					if (!ai_ras_low)
					begin
						col_phase_q <= 1'b0;
						dly_q <= 3'h0;
					end
					else if (dly_q != 3'h7)
						dly_q <= dly_q + 3'h1;
					if (ai_ras_low && dly_q == 3'(dim_pkg::ROW_HOLD_CYC))
						col_phase_q <= 1'b1;
				end
				dim_pkg::DIM_AUTO_ACCESS:
				begin
					// Timed purely from row strobe input
					if (ras_in_s)
					begin
						col_phase_q <= 1'b0;
						dly_q <= 3'h0;
					end
					else if (dly_q != 3'h7)
						dly_q <= dly_q + 3'h1;
					if (!ras_in_s && dly_q == 3'(dim_pkg::AUTO_RAS_CYC
						+ dim_pkg::ROW_HOLD_CYC))
						col_phase_q <= 1'b1;
				end
				default:
				begin
					// External timing: select low means columns
					col_phase_q <= !rc_s;
					if (rc_fall || (cas_fall && !rc_s))
						dly_q <= 3'h0;
					else if (dly_q != 3'h7)
						dly_q <= dly_q + 3'h1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Refresh counter: advances after each init write cycle ends
	logic ai_end;
	assign ai_end = is_ai && gclk_fall && gdiv_q == 2'h3;
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rcnt_q <= dim_pkg::CNT_RST;
		else if (ai_end)
			rcnt_q <= (rcnt_q == eoc_val(eoc_sel)) ? dim_pkg::CNT_RST :
				rcnt_q + 9'h001;
	end

	////////////////////////////////////////////////////////////////////
	// Refresh request flag for automatic access
	always_ff @(posedge mclk)
	begin
		if (!rst_n || !is_aa)
			req_q <= 1'b0;
		else if (rc_rise)
			req_q <= 1'b1;
		else if ((rc_s && cs_n_s && ras_fall) || !refresh_request_in_s)
			req_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Output strobes, address and refresh pin
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			mux_address_out <= dim_pkg::CNT_RST;
			mux_address_oe <= 1'b0;
			row_strobe_n <= dim_pkg::RAS_IDLE;
			column_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			refresh_io_o <= 1'b1;
			refresh_io_oe <= 1'b0;
		end
		else
		begin
			unique case (mode_sel)
				dim_pkg::DIM_AUTO_INIT:
				begin
					mux_address_oe <= 1'b1;
					// Row from counter, then column latch
					mux_address_out <= col_phase_q ? col_lat_q : rcnt_q;
					row_strobe_n <= ai_ras_low ? 4'h0 : 4'hF;
					// One setup cycle after the column goes out
					column_strobe_n <= !(col_phase_q && dly_q >
						3'(dim_pkg::ROW_HOLD_CYC + dim_pkg::COL_SETUP_CYC));
					write_strobe_n <= 1'b0;
					// Open-drain low at counter end clocks column counter
					refresh_io_oe <= rcnt_q == eoc_val(eoc_sel);
					refresh_io_o <= 1'b0;
				end
				dim_pkg::DIM_PROC_INIT:
				begin
					mux_address_oe <= 1'b1;
					mux_address_out <= col_phase_q ? col_lat_q : row_lat_q;
					row_strobe_n <= {4{ras_in_s}};
					column_strobe_n <= cas_in_s || !col_phase_q;
					write_strobe_n <= win_s;
					refresh_io_oe <= 1'b0;
					refresh_io_o <= 1'b1;
				end
				dim_pkg::DIM_EXT_ACCESS:
				begin
					mux_address_oe <= !cs_n_s;
					if (refresh_request_in_s && rc_s && !cs_n_s)
						mux_address_out <= row_lat_q;
					else if (col_phase_q && dly_q >= 3'(dim_pkg::EXT_COL_CYC - 1))
						mux_address_out <= col_lat_q;
					row_strobe_n <= (ras_in_s || cs_n_s) ? 4'hF :
						~bank_dec(bank_q);
					if (!col_phase_q)
						column_strobe_n <= 1'b1;
					else if (cas_in_s && dly_q == 3'h0)
						column_strobe_n <= 1'b1;
					else if (!cas_in_s && dly_q >= 3'(dim_pkg::AUTO_CAS_CYC))
						column_strobe_n <= 1'b0;
					write_strobe_n <= win_s;
					refresh_io_oe <= 1'b0;
					refresh_io_o <= 1'b1;
				end
				dim_pkg::DIM_AUTO_ACCESS:
				begin
					mux_address_oe <= !cs_n_s;
					mux_address_out <= col_phase_q ? col_lat_q : row_lat_q;
					if (ras_in_s)
						row_strobe_n <= 4'hF;
					else if (!refresh_request_in_s || (rc_s && cs_n_s && req_q))
						row_strobe_n <= 4'h0;
					else if (dly_q >= 3'(dim_pkg::AUTO_RAS_CYC - 1) && !cs_n_s)
						row_strobe_n <= ~bank_dec(bank_q);
					// Column strobe a setup cycle after the column address;
					// a refresh is row strobe only, and a stale phase from
					// another mode must not strobe before the row does
					column_strobe_n <= !(col_phase_q && !ras_in_s && refresh_request_in_s &&
						!cs_n_s && dly_q > 3'(dim_pkg::AUTO_RAS_CYC +
						dim_pkg::ROW_HOLD_CYC + dim_pkg::COL_SETUP_CYC));
					write_strobe_n <= win_s;
					refresh_io_oe <= req_q && !rc_s;
					refresh_io_o <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	// Outputs lag one edge, so each check except the two on column strobe falls waits for a settled prior cycle
	chk_init_we_low: assert property (
		@(posedge mclk) disable iff (!rst_n)
		is_ai && $past(is_ai) && $past(rst_n) |-> write_strobe_n == 1'b0)
		else $error("write strobe not low in init");
	chk_init_col_after_ras: assert property (
		@(posedge mclk) disable iff (!rst_n)
		is_ai && $fell(column_strobe_n) |-> row_strobe_n == 4'h0)
		else $error("column strobe without row strobe");
	chk_ext_one_bank: assert property (
		@(posedge mclk) disable iff (!rst_n)
		mode_sel == dim_pkg::DIM_EXT_ACCESS && $past(mode_sel) ==
		dim_pkg::DIM_EXT_ACCESS && row_strobe_n != 4'hF
		|-> $onehot(~row_strobe_n))
		else $error("more than one bank strobed");
	chk_proc_all_banks: assert property (
		@(posedge mclk) disable iff (!rst_n)
		mode_sel == dim_pkg::DIM_PROC_INIT && $past(mode_sel) ==
		dim_pkg::DIM_PROC_INIT |-> row_strobe_n == {4{$past(ras_in_s)}})
		else $error("row strobes not following input");
	chk_aa_cas_late: assert property (
		@(posedge mclk) disable iff (!rst_n)
		is_aa && $fell(column_strobe_n) |-> $past(row_strobe_n, 2) != 4'hF)
		else $error("column strobe too early");
	chk_aa_req_pin: assert property (
		@(posedge mclk) disable iff (!rst_n)
		is_aa && $past(is_aa) && $past(req_q) && !$past(rc_s)
		|-> refresh_io_oe)
		else $error("refresh request not driven");
	chk_init_eoc_pin: assert property (
		@(posedge mclk) disable iff (!rst_n)
		is_ai && $past(is_ai) && $past(rcnt_q) == eoc_val($past(eoc_sel))
		|-> refresh_io_oe && !refresh_io_o)
		else $error("refresh pin not low at count end");
	// Decode written out as a table so it does not mirror the function
	chk_ext_bank_decode: assert property (
		@(posedge mclk) disable iff (!rst_n)
		mode_sel == dim_pkg::DIM_EXT_ACCESS && $past(mode_sel) ==
		dim_pkg::DIM_EXT_ACCESS && row_strobe_n != 4'hF
		|-> row_strobe_n == (($past(bank_q) == 2'h0) ? 4'hE :
		($past(bank_q) == 2'h1) ? 4'hD :
		($past(bank_q) == 2'h2) ? 4'hB : 4'h7))
		else $error("bank decode wrong");
endmodule
`default_nettype wire

// ---- design/dim_pkg.sv ----
/*
 Package for the memory address multiplexer and strobe generator:
 mode encodings, widths, reset values and timing counts.
 Assumes a 25 MHz mclk (40 ns period).
*/
package dim_pkg;
	// Operating modes chosen by the mode selection input
	typedef enum logic [1:0] {
		DIM_AUTO_INIT,
		DIM_PROC_INIT,
		DIM_EXT_ACCESS,
		DIM_AUTO_ACCESS
	} dim_mode_t;

	// Address widths and bank count
	localparam int ADDR_W = 9;
	localparam int BANKS = 4;
	localparam int CNT_W = 9;

	// Clock period in ns
	localparam int CLK_NS = 40;

	// Times in ns as printed
	localparam int ROW_HOLD_NS = 30;
	localparam int COL_SETUP_NS = 14;
	localparam int EXT_COL_NS = 40;
	localparam int AUTO_CAS_NS = 20;
	localparam int AUTO_RAS_NS = 27;

	// Least times round up, typical ones taken likewise; at least one cycle
	localparam int ROW_HOLD_CYC = (ROW_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int COL_SETUP_CYC = (COL_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int EXT_COL_CYC = (EXT_COL_NS + CLK_NS - 1) / CLK_NS;
	localparam int AUTO_CAS_CYC = (AUTO_CAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int AUTO_RAS_CYC = (AUTO_RAS_NS + CLK_NS - 1) / CLK_NS;

	// Strobe generator clock periods per half of an init write cycle
	localparam logic [1:0] INIT_HALF_PER = 2'h2;

	// Counter end values selected by the count select
	localparam logic [8:0] EOC_127 = 9'h07F;
	localparam logic [8:0] EOC_255 = 9'h0FF;
	localparam logic [8:0] EOC_511 = 9'h1FF;

	// Reset values
	localparam logic [1:0] BANK_RST = 2'h0;
	localparam logic [8:0] CNT_RST = 9'h000;
	localparam logic [3:0] RAS_IDLE = 4'hF;
endpackage

// ---- design/dim_sync.sv ----
/*
 Two flip-flop synchroniser bank for asynchronous pins.
 Assumes inputs come from outside the mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dim_sync #(
	parameter int W = 1
)(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	// First stage, read only by the second stage
	logic [W-1:0] meta_q;

	////////////////////////////////////////////////////////////////////
	// Two stages; idle value high since all pins are active low or idle
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			meta_q <= '1;
			sync_out <= '1;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ---- sim/dim_col_cnt.sv ----
/*
 Far-side column counter used during automatic init.
 Assumes refresh_pin is the resolved open-drain refresh_io line.
*/
`timescale 1ns/1ps
`default_nettype none
module dim_col_cnt (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic refresh_pin,
	input wire logic en,
	input wire logic kill,
	output logic [7:0] cnt_q,
	output logic drive
);
	logic pin_q; // Last pin level
	logic dead_q; // Disabled for good once set
	////////////////////////////////////////////////////////////////
	// Advance on a falling pin, seen on the system clock
	always_ff @(posedge mclk)
	begin
		pin_q <= refresh_pin;
		if (!rst_n)
			cnt_q <= 8'h00;
		else if (pin_q && !refresh_pin)
			cnt_q <= cnt_q + 8'h01;
	end
	// Kill latches so a late refresh_io pulse cannot re-enable it
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			dead_q <= 1'b0;
		else if (kill)
			dead_q <= 1'b1;
	end
	// Outputs float unless enabled in init mode and not yet killed
	assign drive = en && !dead_q;
endmodule
`default_nettype wire

// ---- sim/dim_ctrl_test.sv ----
/*
 Self-checking bench for the address mux and strobe generator.
 Assumes the column counter model and 25 MHz mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dim_ctrl_test;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	dim_pkg::dim_mode_t mode = dim_pkg::DIM_AUTO_INIT;
	logic [1:0] bank = 2'h0;
	logic [8:0] row = 9'h000, tcol = 9'h000;
	logic als = 1'b1, cs_n = 1'b0, ras_n = 1'b1, cas_n = 1'b1;
	logic rc = 1'b0, rfq_n = 1'b1, gen_on = 1'b0, kill = 1'b0;
	logic win_n = 1'b1; // Write request from the system
	logic [8:0] q;
	logic q_oe, cas_o, we_o, rf_o, rf_oe, drv;
	logic [3:0] ras_o;
	logic [7:0] cnt;
	// Pull-up on the open-drain line
	wire logic pin = rf_oe ? 1'b0 : 1'b1;
	int n_mismatch = 0, n_tests = 0;
	////////////////////////////////////////////////////////////////
	dim_ctrl u_dim_ctrl (.mclk(mclk), .rst_n(rst_n), .mode_sel(mode),
		.eoc_sel(2'h0), .row_addr_in(row),
		.col_addr_in(drv ? {1'b0, cnt} : tcol), .bank_sel_in(bank),
		.address_latch_strobe(als), .device_select_n(cs_n),
		.row_strobe_in_n(ras_n), .column_strobe_in_n(cas_n),
		.row_column_select(rc), .refresh_request_in_n(rfq_n),
		.write_in_n(win_n), .mux_address_out(q), .mux_address_oe(q_oe),
		.row_strobe_n(ras_o), .column_strobe_n(cas_o),
		.write_strobe_n(we_o), .refresh_io_o(rf_o),
		.refresh_io_oe(rf_oe));
	dim_col_cnt u_dim_col_cnt (.mclk(mclk), .rst_n(rst_n),
		.refresh_pin(pin), .en(mode == dim_pkg::DIM_AUTO_INIT),
		.kill(kill), .cnt_q(cnt), .drive(drv));
	////////////////////////////////////////////////////////////////
	// Clock, and a slow strobe generator clock of 8 mclk periods
	initial
		forever #20 mclk = ~mclk;
	always
	begin
		@(posedge mclk);
		if (gen_on)
		begin
			repeat (3) @(posedge mclk);
			#1 cas_n = ~cas_n;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input string s, input logic [8:0] e,
		input logic [8:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Automatic init: row per write, column from counter, 127 end
	task automatic t_init;
		logic [3:0] pr;
		int rows, lo;
		rows = 0;
		lo = 0;
		pr = 4'hF;
		gen_on = 1'b1;
		for (int i = 0; i < 6000 && !rf_oe; i++)
		begin
			tick(1);
			if (i > 8) chk("we", 9'h000, {8'h00, we_o});
			if (pr == 4'hF && ras_o != 4'hF)
			begin
				chk("init ras", 9'h000, {5'h00, ras_o});
				chk("init row", 9'(rows), q);
				rows++;
			end
			if (ras_o == 4'h0) lo++;
			if (pr == 4'h0 && ras_o == 4'hF)
			begin
				chk("low span", 9'h010, 9'(lo));
				lo = 0;
			end
			if (!cas_o && rows < 127)
				chk("init col", {1'b0, cnt}, q);
			pr = ras_o;
		end
		chk("eoc", 9'h001, {8'h00, rf_oe});
		tick(4);
		chk("col step", 9'h001, {1'b0, cnt});
		kill = 1'b1;
		gen_on = 1'b0;
		tick(9);
		cas_n = 1'b1;
		mode = dim_pkg::DIM_EXT_ACCESS;
		tick(8);
	endtask
	// External access: one bank per pass, both column strobe cases
	task automatic t_ext;
		for (int b = 0; b < 4; b++)
		begin
			bank = b[1:0];
			row = 9'h0A0 + 9'(b);
			tcol = 9'h150 + 9'(b);
			rc = 1'b1;
			cas_n = b[0];
			tick(6);
			chk("row out", row, q);
			chk("oe", 9'h001, {8'h00, q_oe});
			ras_n = 1'b0;
			tick(8);
			chk("bank ras", {5'h00, ~(4'h1 << b)}, {5'h00, ras_o});
			rc = 1'b0;
			tick(6);
			chk("col out", tcol, q);
			chk("cas", {8'h00, b[0]}, {8'h00, cas_o});
			cas_n = 1'b0;
			tick(6);
			chk("cas late", 9'h000, {8'h00, cas_o});
			ras_n = 1'b1;
			cas_n = 1'b1;
			rc = 1'b1;
			tick(6);
		end
	endtask
	// Processor init: every bank follows the row strobe input
	task automatic t_proc;
		bank = 2'h3;
		mode = dim_pkg::DIM_PROC_INIT;
		tick(4);
		ras_n = 1'b0;
		tick(8);
		chk("all ras", 9'h000, {5'h00, ras_o});
		// Columns first, then the column strobe input takes over
		rc = 1'b0;
		cas_n = 1'b0;
		tick(6);
		chk("proc cas", 9'h000, {8'h00, cas_o});
		ras_n = 1'b1;
		cas_n = 1'b1;
		row = row + 9'h001;
		tick(6);
	endtask
	// Automatic access order, then a refresh request and forced cycle
	task automatic t_auto;
		int tr, tc, tk;
		logic seen, cz;
		tr = 99;
		tc = 99;
		tk = 99;
		seen = 1'b0;
		cz = 1'b0;
		mode = dim_pkg::DIM_AUTO_ACCESS;
		bank = 2'h2;
		row = 9'h033;
		tcol = 9'h1CC;
		tick(6);
		win_n = 1'b0;
		als = 1'b0;
		ras_n = 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			tick(1);
			cas_n = i[1];
			if (tr == 99 && ras_o === 4'hB && q === row) tr = i;
			if (tc == 99 && q === tcol) tc = i;
			if (tk == 99 && cas_o === 1'b0) tk = i;
		end
		chk("row first", 9'h001, {8'h00, tr < tc});
		chk("cas last", 9'h001, {8'h00, tc < tk && tk < 99});
		chk("we auto", 9'h000, {8'h00, we_o});
		win_n = 1'b1;
		ras_n = 1'b1;
		cas_n = 1'b1;
		als = 1'b1;
		tick(8);
		rc = 1'b1;
		tick(8);
		rc = 1'b0;
		tick(8);
		chk("rf req", 9'h001, {8'h00, rf_oe});
		rfq_n = 1'b0;
		ras_n = 1'b0;
		for (int i = 0; i < 40; i++)
		begin
			tick(1);
			if (ras_o === 4'h0) seen = 1'b1;
			if (cas_o !== 1'b1) cz = 1'b1;
		end
		chk("forced", 9'h001, {8'h00, seen});
		chk("rf done", 9'h000, {8'h00, rf_oe});
		chk("forced cas", 9'h000, {8'h00, cz});
		ras_n = 1'b1;
		rfq_n = 1'b1;
		// Hidden refresh: deselected strobe while the refresh clock is high
		rc = 1'b1;
		tick(8);
		cs_n = 1'b1;
		ras_n = 1'b0;
		tick(8);
		chk("hidden", 9'h000, {5'h00, ras_o});
		ras_n = 1'b1;
		tick(4);
		cs_n = 1'b0;
		rc = 1'b0;
		tick(8);
		chk("no req", 9'h000, {8'h00, rf_oe});
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#800000;
		n_mismatch++;
		complete_run();
	end
	initial
	begin
		tick(4);
		rst_n = 1'b1;
		tick(3);
		t_init();
		t_ext();
		t_proc();
		t_auto();
		complete_run();
	end
endmodule
`default_nettype wire
